// ===== hdl/gspt_pkg.sv
// Purpose: constants and carrier types of the galvo serial position sender
// Assumes: 20 MHz system clock, 2 MHz link clock made by division
// Notes: register offsets are byte addresses on the plain register port
package gspt_pkg;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int LINK_PERIOD_NS = 500;
   localparam int FRAME_US = 10;
   localparam int LINK_HALF = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int FRAME_CLKS = (FRAME_US * 1000) / LINK_PERIOD_NS;
   localparam logic [2:0] DIV_LAST = 3'(LINK_HALF - 1);
   localparam logic [4:0] LAST_SLOT = 5'(FRAME_CLKS - 1);

   // -------------------------------------------------------------
   // data layout
   // -------------------------------------------------------------
   localparam int POS_W = 24;
   localparam int POS_LSB = 8;
   localparam int STATUS_W = 16;
   localparam int CTRL_FMT_LSB = 14;
   localparam int CTRL_ODD_BIT = 0;
   localparam int STAT_PAR_BIT = 16;
   localparam logic [1:0] FMT_16 = 2'h0;
   localparam logic [1:0] FMT_18 = 2'h1;
   localparam logic [1:0] FMT_20 = 2'h2;
   localparam int INT16_W = 16;
   localparam int INT18_W = 18;
   localparam int INT20_W = 20;

   // -------------------------------------------------------------
   // register offsets and reset values
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_X_POS = 8'h00;
   localparam logic [7:0] OFS_Y_POS = 8'h04;
   localparam logic [7:0] OFS_Z_POS = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] OFS_PLANAR_STAT = 8'h10;
   localparam logic [7:0] OFS_HEIGHT_STAT = 8'h14;
   localparam logic [POS_W-1:0] POS_RESET = 24'h000000;
   localparam logic [1:0] FMT_RESET = 2'h0;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic planarLinkClock;
      logic planarFrameSync;
      logic xPositionLine;
      logic yPositionLine;
   } gspt_planar_s;

   typedef struct packed {
      logic heightLinkClock;
      logic heightFrameSync;
      logic zPositionLine;
   } gspt_height_s;

   typedef struct packed {
      logic parity;
      logic [STATUS_W-1:0] word;
   } gspt_status_s;

endpackage

// ===== hdl/gspt_position_tx.sv
// Purpose: sends x, y, z command positions over a clocked serial link
// Assumes: status lines are asynchronous to clk and are synchronised here
// Notes: data changes on the link clock rising edge, status sampled on fall
`timescale 1ns/1ns
module gspt_position_tx (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   // planar interface
   output gspt_pkg::gspt_planar_s planarLink,
   input wire logic planarStatusLine,
   // height interface
   output gspt_pkg::gspt_height_s heightLink,
   input wire logic heightStatusLine
);
   import gspt_pkg::*;

   // -------------------------------------------------------------
   // frame builder
   // -------------------------------------------------------------
   // integer field is the untouched top of the signed position
   function automatic logic [FRAME_CLKS-1:0] buildFrame(
      input logic [POS_W-1:0] pos,
      input logic [1:0] fmt,
      input logic odd
   );
      logic [INT16_W-1:0] d16;
      logic [INT18_W-1:0] d18;
      logic [INT20_W-1:0] d20;
      logic [FRAME_CLKS-1:0] f;
      d16 = pos[POS_W-1 -: INT16_W];
      d18 = pos[POS_W-1 -: INT18_W];
      d20 = pos[POS_W-1 -: INT20_W];
      case (fmt)
         FMT_20: begin
            f = d20;
         end
         FMT_18: begin
            f = {1'b0, d18, (^d18) ^ odd};
         end
         default: begin
            f = {3'h0, d16, (^d16) ^ odd};
         end
      endcase
      return f;
   endfunction

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [POS_W-1:0] xPos_q;
   logic [POS_W-1:0] yPos_q;
   logic [POS_W-1:0] zPos_q;
   logic [1:0] positionFormatSelect_q;
   logic oddParity_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   wire wrX = regWrite && (regAddr == OFS_X_POS);
   wire wrY = regWrite && (regAddr == OFS_Y_POS);
   wire wrZ = regWrite && (regAddr == OFS_Z_POS);
   wire wrCtrl = regWrite && (regAddr == OFS_CTRL);
   wire [POS_W-1:0] wrPos = regWdata[POS_LSB +: POS_W];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xPos_q <= POS_RESET;
         yPos_q <= POS_RESET;
         zPos_q <= POS_RESET;
         positionFormatSelect_q <= FMT_RESET;
         oddParity_q <= 1'b0;
      end else begin
         if (wrX) begin
            xPos_q <= wrPos;
         end
         if (wrY) begin
            yPos_q <= wrPos;
         end
         if (wrZ) begin
            zPos_q <= wrPos;
         end
         if (wrCtrl) begin
            positionFormatSelect_q <= regWdata[CTRL_FMT_LSB +: 2];
            oddParity_q <= regWdata[CTRL_ODD_BIT];
         end
      end
   end

   // -------------------------------------------------------------
   // link clock divider and slot counter
   // -------------------------------------------------------------
   logic [2:0] divCnt_q;
   logic [2:0] divCnt_d;
   logic linkClk_q;
   logic [4:0] slot_q;
   logic [4:0] slot_d;
   logic sync_q;

   wire halfDone = (divCnt_q == DIV_LAST);
   wire riseNow = halfDone && !linkClk_q;
   wire fallNow = halfDone && linkClk_q;
   wire lastSlot = (slot_q == LAST_SLOT);
   wire frameStart = riseNow && lastSlot;

   assign divCnt_d = halfDone ? 3'h0 : divCnt_q + 3'h1;
   assign slot_d = lastSlot ? 5'h0 : slot_q + 5'h1;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         divCnt_q <= 3'h0;
         linkClk_q <= 1'b0;
         slot_q <= LAST_SLOT;
         sync_q <= 1'b0;
      end else begin
         divCnt_q <= divCnt_d;
         if (halfDone) begin
            linkClk_q <= !linkClk_q;
         end
         if (riseNow) begin
            slot_q <= slot_d;
            sync_q <= (slot_d != LAST_SLOT);
         end
      end
   end

   // -------------------------------------------------------------
   // transmit shifters
   // -------------------------------------------------------------
   logic [FRAME_CLKS-1:0] xSh_q;
   logic [FRAME_CLKS-1:0] ySh_q;
   logic [FRAME_CLKS-1:0] zSh_q;

   wire [FRAME_CLKS-1:0] xFrame =
      buildFrame(xPos_q, positionFormatSelect_q, oddParity_q);
   wire [FRAME_CLKS-1:0] yFrame =
      buildFrame(yPos_q, positionFormatSelect_q, oddParity_q);
   wire [FRAME_CLKS-1:0] zFrame =
      buildFrame(zPos_q, positionFormatSelect_q, oddParity_q);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xSh_q <= '0;
         ySh_q <= '0;
         zSh_q <= '0;
      end else if (frameStart) begin
         xSh_q <= xFrame;
         ySh_q <= yFrame;
         zSh_q <= zFrame;
      end else if (riseNow) begin
         xSh_q <= {xSh_q[FRAME_CLKS-2:0], 1'b0};
         ySh_q <= {ySh_q[FRAME_CLKS-2:0], 1'b0};
         zSh_q <= {zSh_q[FRAME_CLKS-2:0], 1'b0};
      end
   end

   // -------------------------------------------------------------
   // link outputs, same timing on both interfaces
   // -------------------------------------------------------------
   assign planarLink.planarLinkClock = linkClk_q;
   assign planarLink.planarFrameSync = sync_q;
   assign planarLink.xPositionLine = xSh_q[FRAME_CLKS-1];
   assign planarLink.yPositionLine = ySh_q[FRAME_CLKS-1];
   assign heightLink.heightLinkClock = linkClk_q;
   assign heightLink.heightFrameSync = sync_q;
   assign heightLink.zPositionLine = zSh_q[FRAME_CLKS-1];

   // -------------------------------------------------------------
   // status receive
   // -------------------------------------------------------------
   logic planarMeta_q;
   logic planarSync_q;
   logic heightMeta_q;
   logic heightSync_q;
   logic [FRAME_CLKS-1:0] planarRx_q;
   logic [FRAME_CLKS-1:0] heightRx_q;
   gspt_status_s planarStat_q;
   gspt_status_s heightStat_q;

   wire captureNow = fallNow && lastSlot;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         planarMeta_q <= 1'b0;
         planarSync_q <= 1'b0;
         heightMeta_q <= 1'b0;
         heightSync_q <= 1'b0;
      end else begin
         planarMeta_q <= planarStatusLine;
         planarSync_q <= planarMeta_q;
         heightMeta_q <= heightStatusLine;
         heightSync_q <= heightMeta_q;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         planarRx_q <= '0;
         heightRx_q <= '0;
      end else if (fallNow) begin
         planarRx_q <= {planarRx_q[FRAME_CLKS-2:0], planarSync_q};
         heightRx_q <= {heightRx_q[FRAME_CLKS-2:0], heightSync_q};
      end
   end

   // last 17 bits of the frame: status word then its parity
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         planarStat_q <= '0;
         heightStat_q <= '0;
      end else if (captureNow) begin
         planarStat_q <= {planarSync_q, planarRx_q[STATUS_W-1:0]};
         heightStat_q <= {heightSync_q, heightRx_q[STATUS_W-1:0]};
      end
   end

   // -------------------------------------------------------------
   // read path, data valid the cycle after the read strobe only
   // -------------------------------------------------------------
   wire [31:0] ctrlView = {16'h0000, positionFormatSelect_q,
      13'h0000, oddParity_q};
   wire [31:0] planarView = {15'h0000, planarStat_q};
   wire [31:0] heightView = {15'h0000, heightStat_q};

   always_comb begin
      rdata_d = 32'h00000000;
      if (regRead) begin
         case (regAddr)
            OFS_X_POS: begin
               rdata_d = {xPos_q, 8'h00};
            end
            OFS_Y_POS: begin
               rdata_d = {yPos_q, 8'h00};
            end
            OFS_Z_POS: begin
               rdata_d = {zPos_q, 8'h00};
            end
            OFS_CTRL: begin
               rdata_d = ctrlView;
            end
            OFS_PLANAR_STAT: begin
               rdata_d = planarView;
            end
            OFS_HEIGHT_STAT: begin
               rdata_d = heightView;
            end
            default: begin
               rdata_d = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign regRdata = rdata_q;

endmodule

// ===== sim/gspt_monitor.sv
// Purpose: link timing and read port checks
// Assumes: single clock domain, reset low active
// Notes: bound to the design from the bench top
`timescale 1ns/1ns
module gspt_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   // link side
   input wire gspt_pkg::gspt_planar_s planarLink,
   input wire logic planarStatusLine,
   input wire gspt_pkg::gspt_height_s heightLink,
   input wire logic heightStatusLine
);
   import gspt_pkg::*;
   wire logic lc = planarLink.planarLinkClock;
   wire logic fs = planarLink.planarFrameSync;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_hi5; lc [*5]; endsequence
   sequence s_lo5; !lc [*5]; endsequence
   property p_clk_hi; $rose(lc) |-> s_hi5 ##1 !lc; endproperty
   property p_clk_lo; $fell(lc) |-> s_lo5 ##1 lc; endproperty
   property p_frame; $rose(fs) |-> ##200 $rose(fs); endproperty
   property p_sync_lo; $fell(fs) |-> (!fs) [*8] ##3 $rose(fs); endproperty
   property p_sync_edge; $changed(fs) |-> $rose(lc); endproperty
   property p_data_edge;
      $changed(planarLink.xPositionLine) |-> $rose(lc);
   endproperty
   property p_twin;
      heightLink.heightLinkClock == lc && heightLink.heightFrameSync == fs;
   endproperty
   property p_rd_idle; !$past(regRead) |-> regRdata == 32'h0; endproperty
   a_clk_hi: assert property (p_clk_hi) else $error("link high time");
   a_clk_lo: assert property (p_clk_lo) else $error("link low time");
   a_frame: assert property (p_frame) else $error("frame period");
   a_sync_lo: assert property (p_sync_lo) else $error("sync low slot");
   a_sync_edge: assert property (p_sync_edge) else $error("sync edge");
   a_data_edge: assert property (p_data_edge) else $error("data edge");
   a_twin: assert property (p_twin) else $error("interfaces differ");
   a_rd_idle: assert property (p_rd_idle) else $error("read idle");
endmodule

// ===== sim/gspt_scanner_model.sv
// Purpose: scanner head replying a status word each frame
// Assumes: reply bits change on link clock rise
// Notes: parity may be flipped on purpose
`timescale 1ns/1ns
module gspt_scanner_model #(
   parameter logic [15:0] WORD = 16'h0,
   parameter logic FLIP = 1'b0
) (
   // link from the device
   input wire logic linkClock,
   input wire logic frameSync,
   // status reply
   output logic statusLine
);
   logic [4:0] slot = 5'h0;
   wire logic [16:0] reply = {WORD, ^WORD ^ FLIP};
   initial statusLine = 1'b0;
   always @(negedge linkClock) slot <= frameSync ? slot + 5'h1 : 5'h0;
   // word in slots 3..18, parity in slot 19, toggling filler elsewhere
   always @(posedge linkClock) begin
      if (slot >= 5'h3 && slot <= 5'h13) begin
         statusLine <= reply[5'h13 - slot];
      end else begin
         statusLine <= ~statusLine;
      end
   end
endmodule

// ===== sim/galvo_serial_position_tx_tb_top.sv
// Purpose: register and frame tests of the position sender
// Assumes: 50 ns clock, bits sampled mid link period
// Notes: status replies come from two scanner models
`timescale 1ns/1ns
module galvo_serial_position_tx_tb_top;
   import gspt_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] regAddr = 8'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] rdat;
   gspt_planar_s pl;
   gspt_height_s hl;
   logic pst, hst;
   logic [19:0] cx, cy, cz;
   int err_total = 0;
   int n_checks = 0;
   localparam logic [23:0] PX = 24'h8a5c3f;
   localparam logic [23:0] PY = 24'h13579b;
   localparam logic [23:0] PZ = 24'hf0f0f7;
   initial forever #25 clk = ~clk;
   gspt_position_tx dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(rdat), .planarLink(pl), .planarStatusLine(pst),
      .heightLink(hl), .heightStatusLine(hst));
   gspt_scanner_model #(.WORD(16'hc3a5), .FLIP(1'b1)) pm (
      .linkClock(pl.planarLinkClock), .frameSync(pl.planarFrameSync),
      .statusLine(pst));
   gspt_scanner_model #(.WORD(16'h5a17), .FLIP(1'b0)) hm (
      .linkClock(hl.heightLinkClock), .frameSync(hl.heightFrameSync),
      .statusLine(hst));
   task results;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(rdat, e, "read");
   endtask
   function logic [19:0] fexp(input logic [23:0] p, input logic [1:0] f,
                              input logic o);
      case (f)
         2'h1: fexp = {1'b0, p[23:6], ^p[23:6] ^ o};
         2'h2: fexp = p[23:4];
         default: fexp = {3'h0, p[23:8], ^p[23:8] ^ o};
      endcase
   endfunction
   // captures the first frame that starts after the next sync low slot
   task chkf(input logic [1:0] f, input logic o, input logic [23:0] a,
             input logic [23:0] b, input logic [23:0] c);
      int n;
      @(negedge clk);
      for (n = 0; n < 500 && pl.planarFrameSync; n++) @(negedge clk);
      for (n = n; n < 500 && !pl.planarFrameSync; n++) @(negedge clk);
      if (n >= 500) begin
         err_total++;
         results;
      end
      for (n = 0; n < 20; n++) begin
         repeat (n == 0 ? 5 : 10) @(negedge clk);
         cx = {cx[18:0], pl.xPositionLine};
         cy = {cy[18:0], pl.yPositionLine};
         cz = {cz[18:0], hl.zPositionLine};
      end
      chk({12'h0, cx}, {12'h0, fexp(a, f, o)}, "x");
      chk({12'h0, cy}, {12'h0, fexp(b, f, o)}, "y");
      chk({12'h0, cz}, {12'h0, fexp(c, f, o)}, "z");
   endtask
   initial begin
      int m;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_X_POS, 32'h0);
      rd(OFS_CTRL, 32'h0);
      chkf(2'h0, 1'b0, 24'h0, 24'h0, 24'h0);
      wr(OFS_X_POS, {PX, 8'h5a});
      wr(OFS_Y_POS, {PY, 8'hc3});
      wr(OFS_Z_POS, {PZ, 8'h0f});
      wr(8'h20, 32'hffffffff);
      rd(8'h20, 32'h0);
      rd(OFS_X_POS, {PX, 8'h00});
      rd(OFS_Z_POS, {PZ, 8'h00});
      for (m = 0; m < 8; m++) begin
         wr(OFS_CTRL, {16'h0, m[2:1], 13'h0, m[0]});
         chkf(m[2:1], m[0], PX, PY, PZ);
         rd(OFS_CTRL, {16'h0, m[2:1], 13'h0, m[0]});
      end
      rd(OFS_PLANAR_STAT, {15'h0, ~^16'hc3a5, 16'hc3a5});
      rd(OFS_HEIGHT_STAT, {15'h0, ^16'h5a17, 16'h5a17});
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_Y_POS, 32'h0);
      chkf(2'h0, 1'b0, 24'h0, 24'h0, 24'h0);
      results;
   end
endmodule
bind gspt_position_tx gspt_monitor mon (.clk(clk), .nrst(nrst),
   .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .planarLink(planarLink),
   .planarStatusLine(planarStatusLine), .heightLink(heightLink),
   .heightStatusLine(heightStatusLine));
